// ==== verilog/dmi_device.sv ====
// Purpose: switch end of both media links plus management slave
// Assumes: link logic runs on link_clk, user side and management on clk
// Notes: the buffer and port modules here are shared with the partner end
`timescale 1ns/1ps
module dmi_buf #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic wp_q, rp_q;
  logic [1:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = cnt_q != 2'h2;
  assign out_valid = cnt_q != 2'h0;
  assign out_data = mem_q[rp_q];
  always_ff @(posedge clk) begin
    if (push) mem_q[wp_q] <= in_data;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wp_q <= wp_q ^ push;
      rp_q <= rp_q ^ pop;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : dmi_buf

module dmi_end_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic rmii,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [3:0] tx_nibble,
  input wire logic tx_error,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [3:0] rx_nibble,
  output logic rx_error,
  output logic rx_drop,
  output logic [3:0] out_nibble,
  output logic out_enable,
  output logic out_error,
  input wire logic [3:0] in_nibble,
  input wire logic in_valid,
  input wire logic in_error
);
  import dmi_pkg::*;
  // user side: head word is held stable while its toggle request is open
  logic [NIB_W:0] head, hold_q;
  logic head_valid, busy_q, req_q, ack_seen_q, rx_seen_q, rx_drop_q;
  logic [2:0] ack_s_q, rx_s_q;
  logic rx_push_ready;
  wire ack_chg = (ack_s_q[1] == ack_s_q[2]) && (ack_s_q[2] != ack_seen_q);
  wire launch = head_valid && !busy_q;
  wire rx_chg = (rx_s_q[1] == rx_s_q[2]) && (rx_s_q[2] != rx_seen_q);
  // link side
  logic [2:0] lrst_s_q, req_s_q, rmii_s_q;
  logic rmii_l_q, req_seen_q, half_q, ack_q, got_lo_q, err_acc_q, rx_tgl_q;
  logic [3:0] out_nib_q;
  logic out_en_q, out_err_q;
  logic [1:0] lo_q;
  // two slots so a word stays put for two link cycles while it crosses
  logic [NIB_W:0] rxw_q [2];
  wire lrst = lrst_s_q[2];
  wire req_chg = (req_s_q[1] == req_s_q[2]) && (req_s_q[2] != req_seen_q);
  wire [3:0] rx_nib = rmii_l_q ? {in_nibble[1:0], lo_q} : in_nibble;
  wire rx_done = in_valid && (!rmii_l_q || got_lo_q);
  wire rx_err = err_acc_q || in_error;

  dmi_buf #(.W(NIB_W + 1)) u_txb (
    .clk(clk),
    .rst(rst),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data({tx_error, tx_nibble}),
    .out_valid(head_valid),
    .out_ready(launch),
    .out_data(head)
  );
  dmi_buf #(.W(NIB_W + 1)) u_rxb (
    .clk(clk),
    .rst(rst),
    .in_valid(rx_chg),
    .in_ready(rx_push_ready),
    .in_data(rxw_q[rx_s_q[2]]),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data({rx_error, rx_nibble})
  );
  assign rx_drop = rx_drop_q;

  always_ff @(posedge clk) begin
    ack_s_q <= {ack_s_q[1:0], ack_q};
    rx_s_q <= {rx_s_q[1:0], rx_tgl_q};
    if (rst) begin
      busy_q <= 1'b0;
      req_q <= 1'b0;
      hold_q <= '0;
      ack_seen_q <= 1'b0;
      rx_seen_q <= 1'b0;
      rx_drop_q <= 1'b0;
    end else begin
      rx_drop_q <= rx_chg && !rx_push_ready;
      if (rx_chg) rx_seen_q <= rx_s_q[2];
      if (ack_chg) ack_seen_q <= ack_s_q[2];
      if (launch) begin
        hold_q <= head;
        req_q <= ~req_q;
      end
      busy_q <= launch || (busy_q && !ack_chg);
    end
  end

  assign out_nibble = out_nib_q;
  assign out_enable = out_en_q;
  assign out_error = out_err_q;

  always_ff @(posedge link_clk) begin
    lrst_s_q <= {lrst_s_q[1:0], rst};
    req_s_q <= {req_s_q[1:0], req_q};
    rmii_s_q <= {rmii_s_q[1:0], rmii};
    if (rmii_s_q[1] == rmii_s_q[2]) rmii_l_q <= rmii_s_q[2];
    if (lrst) begin
      out_en_q <= 1'b0;
      out_nib_q <= 4'h0;
      out_err_q <= 1'b0;
      half_q <= 1'b0;
      ack_q <= 1'b0;
      req_seen_q <= 1'b0;
    end else if (half_q) begin
      out_nib_q <= {2'h0, hold_q[3:2]};
      half_q <= 1'b0;
      ack_q <= ~ack_q;
    end else if (req_chg) begin
      req_seen_q <= req_s_q[2];
      out_en_q <= 1'b1;
      out_err_q <= hold_q[NIB_W];
      out_nib_q <= rmii_l_q ? {2'h0, hold_q[1:0]} : hold_q[3:0];
      half_q <= rmii_l_q;
      if (!rmii_l_q) ack_q <= ~ack_q;
    end else begin
      out_en_q <= 1'b0;
      out_nib_q <= 4'h0;
      out_err_q <= 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    if (lrst) begin
      got_lo_q <= 1'b0;
      err_acc_q <= 1'b0;
      rx_tgl_q <= 1'b0;
      lo_q <= 2'h0;
    end else if (rx_done) begin
      rxw_q[~rx_tgl_q] <= {rx_err, rx_nib};
      rx_tgl_q <= ~rx_tgl_q;
      got_lo_q <= 1'b0;
      err_acc_q <= 1'b0;
    end else if (in_valid) begin
      lo_q <= in_nibble[1:0];
      got_lo_q <= 1'b1;
      err_acc_q <= in_error;
    end else begin
      got_lo_q <= 1'b0;
      err_acc_q <= 1'b0;
    end
  end
endmodule : dmi_end_port

module dmi_device (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire dmi_pkg::dmi_mode_t first_mode,
  input wire dmi_pkg::dmi_mode_t second_mode,
  input wire logic [1:0] tx_valid,
  output logic [1:0] tx_ready,
  input wire logic [7:0] tx_nibble,
  output logic [1:0] rx_valid,
  input wire logic [1:0] rx_ready,
  output logic [7:0] rx_nibble,
  output logic [1:0] rx_error,
  output logic [1:0] rx_drop,
  dmi_link_if.device lnk
);
  import dmi_pkg::*;
  logic [2:0] rstn_s_q, mdc_s_q, mdi_s_q;
  logic dev_rst_q, mdc_lvl_q, mdo_q, mdo_oe_n_q;
  dmi_md_state_t st_q;
  logic [5:0] pre_q;
  logic [3:0] cnt_q;
  logic [12:0] hdr_q;
  logic [15:0] sh_q;
  logic [15:0] phy_reg_q [PHY_COUNT][REG_COUNT];
  wire [3:0] out_nib [2];
  wire out_en [2];
  wire mdc_ok = mdc_s_q[1] == mdc_s_q[2];
  wire md_rise = mdc_ok && mdc_s_q[2] && !mdc_lvl_q;
  wire md_fall = mdc_ok && !mdc_s_q[2] && mdc_lvl_q;
  wire md_bit = mdi_s_q[2];
  wire is_rd = hdr_q[11:10] == MD_OP_RD;
  wire op_ok = is_rd || hdr_q[11:10] == MD_OP_WR;
  wire [4:0] phy = hdr_q[9:5];
  wire [4:0] reg_ix = hdr_q[4:0];
  wire phy_hit = phy < 5'(PHY_COUNT);
  wire [15:0] rd_word = phy_hit ? phy_reg_q[phy[2:0]][reg_ix] : 16'h0000;
  wire md_wr = md_rise && st_q == MD_DATA && cnt_q == 4'hF && !is_rd &&
               phy_hit;
  wire [1:0] rmii = {dmi_is_rmii(second_mode), dmi_is_rmii(first_mode)};

  // pin clock is passed out only in the modes where this end sources it
  assign lnk.first_clk_dev_o = {2{link_clk}};
  assign lnk.second_clk_dev_o = {2{link_clk}};
  assign lnk.first_clk_dev_oe_n = ~{dmi_dev_drives_rx(first_mode),
    dmi_dev_drives_tx(first_mode)};
  assign lnk.second_clk_dev_oe_n = ~{dmi_dev_drives_rx(second_mode),
    dmi_dev_drives_tx(second_mode)};
  assign lnk.first_if_tx_nibble = out_nib[0];
  assign lnk.first_if_tx_enable = out_en[0];
  assign lnk.second_if_tx_nibble = out_nib[1];
  assign lnk.second_if_tx_enable = out_en[1];
  assign lnk.mdio_dev_o = mdo_q;
  assign lnk.mdio_dev_oe_n = mdo_oe_n_q;

  wire [3:0] in_nib [2] = '{lnk.first_if_rx_nibble, lnk.second_if_rx_nibble};
  wire in_val [2] = '{lnk.first_if_rx_valid, lnk.second_if_rx_valid};
  wire in_err [2] = '{lnk.first_if_rx_error, lnk.second_if_rx_error};

  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      dmi_end_port u_port (
        .clk(clk),
        .rst(dev_rst_q),
        .link_clk(link_clk),
        .rmii(rmii[p]),
        .tx_valid(tx_valid[p]),
        .tx_ready(tx_ready[p]),
        .tx_nibble(tx_nibble[4*p +: 4]),
        .tx_error(1'b0),
        .rx_valid(rx_valid[p]),
        .rx_ready(rx_ready[p]),
        .rx_nibble(rx_nibble[4*p +: 4]),
        .rx_error(rx_error[p]),
        .rx_drop(rx_drop[p]),
        .out_nibble(out_nib[p]),
        .out_enable(out_en[p]),
        .out_error(),
        .in_nibble(in_nib[p]),
        .in_valid(in_val[p]),
        .in_error(in_err[p])
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    rstn_s_q <= {rstn_s_q[1:0], lnk.reset_n};
    dev_rst_q <= sys_rst || !rstn_s_q[2];
    mdc_s_q <= {mdc_s_q[1:0], lnk.mdc};
    mdi_s_q <= {mdi_s_q[1:0], lnk.mdio};
  end

  always_ff @(posedge clk) begin
    if (md_wr) phy_reg_q[phy[2:0]][reg_ix] <= {sh_q[14:0], md_bit};
  end

  always_ff @(posedge clk) begin
    if (dev_rst_q) begin
      st_q <= MD_IDLE;
      pre_q <= 6'h00;
      cnt_q <= 4'h0;
      hdr_q <= 13'h0000;
      sh_q <= 16'h0000;
      mdc_lvl_q <= 1'b0;
      mdo_q <= 1'b0;
      mdo_oe_n_q <= 1'b1;
    end else begin
      if (mdc_ok) mdc_lvl_q <= mdc_s_q[2];
      if (md_rise) begin
        unique case (st_q)
          MD_IDLE: begin
            if (!md_bit && pre_q == 6'(PRE_LEN)) st_q <= MD_HDR;
            pre_q <= !md_bit ? 6'h00 :
                     (pre_q == 6'(PRE_LEN) ? pre_q : pre_q + 6'h01);
            cnt_q <= 4'h0;
          end
          MD_HDR: begin
            hdr_q <= {hdr_q[11:0], md_bit};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'(HDR_LAST)) begin
              st_q <= MD_TA;
              cnt_q <= 4'h0;
            end
          end
          MD_TA: begin
            cnt_q <= cnt_q + 4'h1;
            if (!hdr_q[12] || !op_ok) begin
              st_q <= MD_IDLE;
            end else if (cnt_q == 4'h1) begin
              st_q <= MD_DATA;
              cnt_q <= 4'h0;
              sh_q <= rd_word;
            end
          end
          MD_DATA: begin
            if (!is_rd) sh_q <= {sh_q[14:0], md_bit};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'hF) st_q <= MD_IDLE;
          end
        endcase
        if (st_q != MD_IDLE) pre_q <= 6'h00;
      end
      if (md_fall) begin
        if (st_q == MD_TA && cnt_q == 4'h1 && is_rd && hdr_q[12]) begin
          mdo_oe_n_q <= 1'b0;
          mdo_q <= 1'b0;
        end else if (st_q == MD_DATA && is_rd) begin
          mdo_q <= sh_q[15];
          sh_q <= {sh_q[14:0], 1'b0};
        end else begin
          mdo_oe_n_q <= 1'b1;
        end
      end
    end
  end
endmodule : dmi_device

// ==== verilog/dmi_pkg.sv ====
// Purpose: shared constants, mode and state types for the dual media link
// Assumes: system clock of 20 MHz; link nibbles cross on a 160 ns link clock
// Notes: clock direction per mode is decided by the functions below
package dmi_pkg;
  localparam int NIB_W = 4;
  localparam int RMII_W = 2;
  localparam int CLK_PERIOD_NS = 50;
  // shortest management clock period, 12.5 MHz
  localparam int MDC_MIN_PERIOD_NS = 80;
  // least half period in system cycles, rounded up
  localparam int MDC_HALF_MIN =
    (MDC_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // default half period; leaves room for the three-stage input sync
  localparam int MDC_HALF = 8 * MDC_HALF_MIN;
  localparam int PRE_LEN = 32;
  localparam int PHY_COUNT = 5;
  localparam int REG_COUNT = 32;
  localparam int FRAME_LEN = 64;
  localparam int TA_POS = 46;
  localparam int DATA_POS = 48;
  localparam int HDR_LAST = 12;
  localparam logic [1:0] MD_START = 2'h1;
  localparam logic [1:0] MD_OP_RD = 2'h2;
  localparam logic [1:0] MD_OP_WR = 2'h1;
  localparam logic [1:0] MD_TA_WR = 2'h2;

  typedef enum logic [2:0] {
    DMI_MII = 3'h0,
    DMI_REVERSE_MEDIA_IF_MODE = 3'h1,
    DMI_RMII_EXT = 3'h2,
    DMI_RMII_INT = 3'h3,
    DMI_TURBO_MEDIA_IF_MODE = 3'h4,
    DMI_REVERSE_TURBO_MEDIA_IF_MODE = 3'h5,
    DMI_RGMII = 3'h6
  } dmi_mode_t;

  typedef enum logic [1:0] {
    MD_IDLE = 2'h0,
    MD_HDR = 2'h1,
    MD_TA = 2'h2,
    MD_DATA = 2'h3
  } dmi_md_state_t;

  function automatic logic dmi_is_rmii(input dmi_mode_t m);
    return m inside {DMI_RMII_EXT, DMI_RMII_INT};
  endfunction : dmi_is_rmii

  function automatic logic dmi_dev_drives_tx(input dmi_mode_t m);
    return m inside {DMI_RGMII, DMI_REVERSE_MEDIA_IF_MODE, DMI_RMII_INT,
                     DMI_REVERSE_TURBO_MEDIA_IF_MODE};
  endfunction : dmi_dev_drives_tx

  function automatic logic dmi_dev_drives_rx(input dmi_mode_t m);
    return m inside {DMI_REVERSE_MEDIA_IF_MODE,
                     DMI_REVERSE_TURBO_MEDIA_IF_MODE};
  endfunction : dmi_dev_drives_rx
endpackage : dmi_pkg

// ==== verilog/dmi_link_if.sv ====
// Purpose: pins between the switch end and the partner end
// Assumes: each two-way pin is split into out and active-low enable
// Notes: resolved levels are formed here; undriven pins pull low
`timescale 1ns/1ps
interface dmi_link_if;
  logic [3:0] first_if_tx_nibble, first_if_rx_nibble;
  logic first_if_tx_enable, first_if_rx_valid, first_if_rx_error;
  logic [3:0] second_if_tx_nibble, second_if_rx_nibble;
  logic second_if_tx_enable, second_if_rx_valid, second_if_rx_error;
  // clock pins, bit 0 transmit clock, bit 1 receive clock
  logic [1:0] first_clk_dev_o, first_clk_dev_oe_n;
  logic [1:0] first_clk_host_o, first_clk_host_oe_n;
  logic [1:0] second_clk_dev_o, second_clk_dev_oe_n;
  logic [1:0] second_clk_host_o, second_clk_host_oe_n;
  logic first_if_tx_clock, first_if_rx_clock;
  logic second_if_tx_clock, second_if_rx_clock;
  logic mdc, mdio, mdio_dev_o, mdio_dev_oe_n, mdio_host_o, mdio_host_oe_n;
  logic reset_n;

  function automatic logic pick(input logic d, input logic d_oe_n,
                                input logic h, input logic h_oe_n);
    return !d_oe_n ? d : (!h_oe_n ? h : 1'b0);
  endfunction : pick

  assign first_if_tx_clock = pick(first_clk_dev_o[0], first_clk_dev_oe_n[0],
    first_clk_host_o[0], first_clk_host_oe_n[0]);
  assign first_if_rx_clock = pick(first_clk_dev_o[1], first_clk_dev_oe_n[1],
    first_clk_host_o[1], first_clk_host_oe_n[1]);
  assign second_if_tx_clock = pick(second_clk_dev_o[0],
    second_clk_dev_oe_n[0], second_clk_host_o[0], second_clk_host_oe_n[0]);
  assign second_if_rx_clock = pick(second_clk_dev_o[1],
    second_clk_dev_oe_n[1], second_clk_host_o[1], second_clk_host_oe_n[1]);
  assign mdio = pick(mdio_dev_o, mdio_dev_oe_n, mdio_host_o, mdio_host_oe_n);

  modport device (
    output first_if_tx_nibble, first_if_tx_enable,
    input first_if_rx_nibble, first_if_rx_valid, first_if_rx_error,
    output second_if_tx_nibble, second_if_tx_enable,
    input second_if_rx_nibble, second_if_rx_valid, second_if_rx_error,
    output first_clk_dev_o, first_clk_dev_oe_n,
    output second_clk_dev_o, second_clk_dev_oe_n,
    input mdc, mdio, reset_n,
    output mdio_dev_o, mdio_dev_oe_n
  );
  modport host (
    input first_if_tx_nibble, first_if_tx_enable,
    output first_if_rx_nibble, first_if_rx_valid, first_if_rx_error,
    input second_if_tx_nibble, second_if_tx_enable,
    output second_if_rx_nibble, second_if_rx_valid, second_if_rx_error,
    output first_clk_host_o, first_clk_host_oe_n,
    output second_clk_host_o, second_clk_host_oe_n,
    input mdio,
    output mdc, mdio_host_o, mdio_host_oe_n, reset_n
  );
endinterface : dmi_link_if

// ==== verilog/dmi_host.sv ====
// Purpose: partner end of both media links plus management master
// Assumes: dmi_end_port from the switch-end file is compiled first
// Notes: this end sends on the receive lines and listens on transmit lines
`timescale 1ns/1ps
module dmi_host #(
  parameter int MDC_HALF_CYC = dmi_pkg::MDC_HALF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire dmi_pkg::dmi_mode_t first_mode,
  input wire dmi_pkg::dmi_mode_t second_mode,
  input wire logic hold_device_reset,
  input wire logic [1:0] tx_valid,
  output logic [1:0] tx_ready,
  input wire logic [7:0] tx_nibble,
  input wire logic [1:0] tx_error,
  output logic [1:0] rx_valid,
  input wire logic [1:0] rx_ready,
  output logic [7:0] rx_nibble,
  output logic [1:0] rx_drop,
  input wire logic mgmt_start,
  input wire logic mgmt_write,
  input wire logic [4:0] mgmt_phy,
  input wire logic [4:0] mgmt_reg,
  input wire logic [15:0] mgmt_wdata,
  output logic mgmt_busy,
  output logic mgmt_done,
  output logic [15:0] mgmt_rdata,
  dmi_link_if.host lnk
);
  import dmi_pkg::*;
  logic [7:0] div_q;
  logic [5:0] cur_q;
  logic [63:0] fr_q;
  logic run_q, rd_q, mdc_q, oe_n_q, done_q, rstn_q;
  logic [15:0] rdata_q;
  wire tick = div_q == 8'(MDC_HALF_CYC - 1);
  wire [5:0] nxt = cur_q + 6'h01;
  wire [1:0] op = mgmt_write ? MD_OP_WR : MD_OP_RD;
  wire [63:0] frame = {32'hFFFFFFFF, MD_START, op, mgmt_phy, mgmt_reg,
                       MD_TA_WR, mgmt_wdata};
  wire [1:0] rmii = {dmi_is_rmii(second_mode), dmi_is_rmii(first_mode)};
  wire [3:0] out_nib [2];
  wire out_en [2];
  wire out_err [2];
  wire [3:0] in_nib [2] = '{lnk.first_if_tx_nibble, lnk.second_if_tx_nibble};
  wire in_val [2] = '{lnk.first_if_tx_enable, lnk.second_if_tx_enable};

  // sources every clock the switch end does not drive; none in RMII receive
  assign lnk.first_clk_host_o = {2{link_clk}};
  assign lnk.second_clk_host_o = {2{link_clk}};
  assign lnk.first_clk_host_oe_n = {dmi_dev_drives_rx(first_mode) ||
    dmi_is_rmii(first_mode), dmi_dev_drives_tx(first_mode)};
  assign lnk.second_clk_host_oe_n = {dmi_dev_drives_rx(second_mode) ||
    dmi_is_rmii(second_mode), dmi_dev_drives_tx(second_mode)};
  assign lnk.first_if_rx_nibble = out_nib[0];
  assign lnk.first_if_rx_valid = out_en[0];
  assign lnk.first_if_rx_error = out_err[0];
  assign lnk.second_if_rx_nibble = out_nib[1];
  assign lnk.second_if_rx_valid = out_en[1];
  assign lnk.second_if_rx_error = out_err[1];
  assign lnk.mdc = mdc_q;
  assign lnk.mdio_host_o = fr_q[63];
  assign lnk.mdio_host_oe_n = oe_n_q;
  assign lnk.reset_n = rstn_q;
  assign mgmt_busy = run_q;
  assign mgmt_done = done_q;
  assign mgmt_rdata = rdata_q;

  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      dmi_end_port u_port (
        .clk(clk),
        .rst(sys_rst),
        .link_clk(link_clk),
        .rmii(rmii[p]),
        .tx_valid(tx_valid[p]),
        .tx_ready(tx_ready[p]),
        .tx_nibble(tx_nibble[4*p +: 4]),
        .tx_error(tx_error[p]),
        .rx_valid(rx_valid[p]),
        .rx_ready(rx_ready[p]),
        .rx_nibble(rx_nibble[4*p +: 4]),
        .rx_error(),
        .rx_drop(rx_drop[p]),
        .out_nibble(out_nib[p]),
        .out_enable(out_en[p]),
        .out_error(out_err[p]),
        .in_nibble(in_nib[p]),
        .in_valid(in_val[p]),
        .in_error(1'b0)
      );
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rstn_q <= 1'b0;
      run_q <= 1'b0;
      rd_q <= 1'b0;
      mdc_q <= 1'b0;
      oe_n_q <= 1'b1;
      done_q <= 1'b0;
      div_q <= 8'h00;
      cur_q <= 6'h00;
      fr_q <= 64'h0;
      rdata_q <= 16'h0000;
    end else begin
      rstn_q <= !hold_device_reset;
      done_q <= 1'b0;
      if (!run_q) begin
        div_q <= 8'h00;
        mdc_q <= 1'b0;
        if (mgmt_start) begin
          run_q <= 1'b1;
          rd_q <= !mgmt_write;
          cur_q <= 6'h00;
          fr_q <= frame;
          oe_n_q <= 1'b0;
        end
      end else begin
        div_q <= tick ? 8'h00 : div_q + 8'h01;
        if (tick) begin
          mdc_q <= ~mdc_q;
          if (!mdc_q && rd_q && cur_q >= 6'(DATA_POS)) begin
            rdata_q <= {rdata_q[14:0], lnk.mdio};
          end
          if (mdc_q && cur_q == 6'(FRAME_LEN - 1)) begin
            run_q <= 1'b0;
            done_q <= 1'b1;
            oe_n_q <= 1'b1;
          end else if (mdc_q) begin
            cur_q <= nxt;
            fr_q <= {fr_q[62:0], 1'b0};
            oe_n_q <= rd_q && nxt >= 6'(TA_POS);
          end
        end
      end
    end
  end
endmodule : dmi_host

// ==== tb/dmi_assertions.sv ====
// Purpose: wire and management checks between the two ends
// Assumes: first link MII, second link RMII, mdc half period 5 clk
// Notes: link checks on link_clk, management checks on clk
`timescale 1ns/1ps
module dmi_assertions #(
  parameter int MDC_HALF_CYC = 5
) (
  input wire logic clk,
  input wire logic link_clk,
  input wire logic sys_rst,
  input wire logic first_if_tx_enable,
  input wire logic [3:0] second_if_tx_nibble,
  input wire logic second_if_tx_enable,
  input wire logic first_if_rx_valid,
  input wire logic first_if_rx_error,
  input wire logic second_if_rx_valid,
  input wire logic mdc,
  input wire logic mdio_dev_oe_n,
  input wire logic mdio_host_oe_n,
  input wire logic reset_n
);
  logic [7:0] mdc_high_q;
  // second dibit of a pair: enable for one more link cycle then gap
  sequence dibit_s;
    second_if_tx_enable ##1 !second_if_tx_enable;
  endsequence
  always_ff @(posedge clk) begin
    mdc_high_q <= mdc ? mdc_high_q + 8'h01 : 8'h00;
  end
  tx_one_cycle_a: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    $rose(first_if_tx_enable) |=> !first_if_tx_enable)
    else $error("first link enable not one cycle");
  rmii_dibit_pair_a: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    $rose(second_if_tx_enable) |=> dibit_s)
    else $error("second link dibits not paired");
  rmii_upper_zero_a: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    second_if_tx_enable |-> second_if_tx_nibble[3:2] == 2'h0)
    else $error("second link upper bits used");
  error_with_valid_a: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    first_if_rx_error |-> first_if_rx_valid)
    else $error("receive error without valid");
  rx_half_pair_a: assert property (
    @(posedge link_clk) disable iff (sys_rst)
    $rose(second_if_rx_valid) |=> second_if_rx_valid)
    else $error("second link receive half missing");
  mdc_half_len_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(mdc) |-> mdc_high_q == MDC_HALF_CYC[7:0])
    else $error("management clock high time wrong");
  mdio_drive_low_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    $fell(mdio_dev_oe_n) |-> !mdc)
    else $error("device took data line with clock high");
  mdio_no_clash_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !mdio_dev_oe_n |-> mdio_host_oe_n)
    else $error("both ends drive data line");
  pin_reset_idle_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !reset_n [*6] |-> mdio_dev_oe_n)
    else $error("data line driven in pin reset");
endmodule : dmi_assertions

// ==== tb/dual_media_indep_port_if_tb.sv ====
// Purpose: drives both user sides and checks traffic and management
// Assumes: mode inputs equal on both ends; mdc half period 5 clk
// Notes: reset held past four link clock edges as the ends need
`timescale 1ns/1ps
module dual_media_indep_port_if_tb;
  import dmi_pkg::*;
  `define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    miscompares++; $display("MISMATCH t=%0t got %h exp %h", $time, a, e); \
  end end
  localparam logic [6:0] TX_DEV = 7'h6A;
  localparam logic [6:0] RX_DEV = 7'h22;
  logic clk = 1'h0, link_clk = 1'h0, sys_rst = 1'h1, hold = 1'h0;
  dmi_mode_t fm = DMI_MII, sm = DMI_RMII_INT;
  logic [1:0] dtv = 2'h0, dtr, drv, drr = 2'h0, dre;
  logic [1:0] htv = 2'h0, htr, hte = 2'h0, hrv, hrr = 2'h0;
  logic [7:0] dtn = 8'h00, drn, htn = 8'h00, hrn;
  logic ms = 1'h0, mw = 1'h0, mb, md;
  logic [4:0] mp = 5'h00, mr = 5'h00;
  logic [15:0] mwd = 16'h0000, mrd;
  logic [3:0] q1[$], q2[$];
  int miscompares = 0, checks_done = 0;
  dmi_link_if u_dmi_link_if ();
  wire [1:0] fco = u_dmi_link_if.first_clk_dev_oe_n;
  wire [1:0] sco = u_dmi_link_if.second_clk_dev_oe_n;
  dmi_device u_dmi_device (.clk(clk), .sys_rst(sys_rst),
    .link_clk(link_clk), .first_mode(fm), .second_mode(sm), .tx_valid(dtv),
    .tx_ready(dtr), .tx_nibble(dtn), .rx_valid(drv), .rx_ready(drr),
    .rx_nibble(drn), .rx_error(dre), .rx_drop(), .lnk(u_dmi_link_if));
  dmi_host #(.MDC_HALF_CYC(5)) u_dmi_host (.clk(clk), .sys_rst(sys_rst),
    .link_clk(link_clk), .first_mode(fm), .second_mode(sm),
    .hold_device_reset(hold), .tx_valid(htv), .tx_ready(htr),
    .tx_nibble(htn), .tx_error(hte), .rx_valid(hrv), .rx_ready(hrr),
    .rx_nibble(hrn), .rx_drop(), .mgmt_start(ms), .mgmt_write(mw),
    .mgmt_phy(mp), .mgmt_reg(mr), .mgmt_wdata(mwd), .mgmt_busy(mb),
    .mgmt_done(md), .mgmt_rdata(mrd), .lnk(u_dmi_link_if));
  dmi_assertions #(.MDC_HALF_CYC(5)) u_dmi_assertions (.clk(clk),
    .link_clk(link_clk), .sys_rst(sys_rst),
    .first_if_tx_enable(u_dmi_link_if.first_if_tx_enable),
    .second_if_tx_nibble(u_dmi_link_if.second_if_tx_nibble),
    .second_if_tx_enable(u_dmi_link_if.second_if_tx_enable),
    .first_if_rx_valid(u_dmi_link_if.first_if_rx_valid),
    .first_if_rx_error(u_dmi_link_if.first_if_rx_error),
    .second_if_rx_valid(u_dmi_link_if.second_if_rx_valid),
    .mdc(u_dmi_link_if.mdc), .mdio_dev_oe_n(u_dmi_link_if.mdio_dev_oe_n),
    .mdio_host_oe_n(u_dmi_link_if.mdio_host_oe_n),
    .reset_n(u_dmi_link_if.reset_n));
  always #25 clk = ~clk;
  initial begin
    #13;
    forever #80 link_clk = ~link_clk;
  end
  // wire view of what the switch end sends
  always @(posedge link_clk) begin
    if (u_dmi_link_if.first_if_tx_enable)
      q1.push_back(u_dmi_link_if.first_if_tx_nibble);
    if (u_dmi_link_if.second_if_tx_enable)
      q2.push_back(u_dmi_link_if.second_if_tx_nibble);
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic send(input logic h, input int k, input logic [3:0] n);
    int t = 0;
    // valid stays low across one edge between two calls
    tick();
    if (h) htn[k*4+:4] = n; else dtn[k*4+:4] = n;
    if (h) htv[k] = 1'h1; else dtv[k] = 1'h1;
    while (!(h ? htr[k] : dtr[k]) && t < 100) begin tick(); t++; end
    if (t == 100) miscompares++;
    tick();
    if (h) htv[k] = 1'h0; else dtv[k] = 1'h0;
  endtask : send
  task automatic recv(input logic h, input int k, input logic [3:0] n,
      input logic e);
    int t = 0;
    logic [3:0] lo, hi;
    tick();
    while (!(h ? hrv[k] : drv[k]) && t < 200) begin tick(); t++; end
    if (t == 200) miscompares++;
    `CHK(h ? hrn[k*4+:4] : drn[k*4+:4], n)
    if (!h) `CHK(dre[k], e)
    if (h && k == 0) begin
      lo = q1.pop_front();
      `CHK(lo, n)
    end
    if (h && k == 1) begin
      lo = q2.pop_front();
      hi = q2.pop_front();
      `CHK({hi[1:0], lo[1:0]}, n)
    end
    if (h) hrr[k] = 1'h1; else drr[k] = 1'h1;
    tick();
    if (h) hrr[k] = 1'h0; else drr[k] = 1'h0;
  endtask : recv
  task automatic mgmt(input logic w, input logic [4:0] p,
      input logic [15:0] d, input logic [15:0] e);
    int t = 0;
    // gap lets the switch end release the data line after a read
    repeat (8) tick();
    ms = 1'h1; mw = w; mp = p; mr = 5'h03; mwd = d;
    tick();
    ms = 1'h0;
    `CHK(mb, 1'h1)
    while (!md && t < 2000) begin tick(); t++; end
    `CHK(md, 1'h1)
    `CHK(mb, 1'h0)
    if (!w) `CHK(mrd, e)
  endtask : mgmt
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial begin
    #1000000;
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (14) tick();
    sys_rst = 1'h0;
    repeat (16) tick();
    for (int k = 0; k < 2; k++) begin
      send(1'h0, k, 4'h8);
      send(1'h0, k, 4'h1);
      recv(1'h1, k, 4'h8, 1'h0);
      recv(1'h1, k, 4'h1, 1'h0);
      send(1'h1, k, 4'hE);
      recv(1'h0, k, 4'hE, 1'h0);
      hte[k] = 1'h1;
      send(1'h1, k, 4'h7);
      hte[k] = 1'h0;
      recv(1'h0, k, 4'h7, 1'h1);
    end
    mgmt(1'h1, 5'h01, 16'hA5C3, 16'h0000);
    mgmt(1'h0, 5'h01, 16'h0000, 16'hA5C3);
    mgmt(1'h0, 5'h05, 16'h0000, 16'h0000);
    send(1'h1, 0, 4'h3);
    repeat (30) tick();
    hold = 1'h1;
    repeat (10) tick();
    `CHK(drv, 2'h0)
    `CHK(u_dmi_link_if.mdio_dev_oe_n, 1'h1)
    // link side reset must settle before the pin is released
    repeat (20) tick();
    hold = 1'h0;
    repeat (20) tick();
    `CHK(drv, 2'h0)
    for (int m = 0; m < 7; m++) begin
      fm = dmi_mode_t'(m);
      sm = fm;
      repeat (16) tick();
      `CHK(fco, ~{RX_DEV[m], TX_DEV[m]})
      if (m < 6) `CHK(sco, ~{RX_DEV[m], TX_DEV[m]})
    end
    stop_test();
  end
endmodule : dual_media_indep_port_if_tb
